// ==== atbc_cmd.sv ====
/*
  atbc_cmd.sv: block transfer command handler with its AXI4-Lite
  task file, sector buffer, media and dma request sides.
  assumes: media side answers each request with one ack pulse;
  dma side answers dma_go_o with one dma_done_i pulse.
*/
// Design decisions made here: the register offsets and register access over AXI4-Lite.
// Operation
// - block read: no interrupt between block sectors
// - long option bit ignored for block commands
// - sector count means sectors, not blocks
// - whole blocks, then one partial block
// - abort block commands when mode disabled
// - read errors reported, data still moved
// - busy within 400 ns of block write
// - write errors end command at failing sector
// - write: data request and interrupt per block
// - valid block count stored and mode enabled
// - unsupported count aborts and disables mode
// - zero disables mode; busy always cleared
// - mode disabled after power on
// - buffer read: busy, request, interrupt, 512 bytes
// - buffer commands share same 512 bytes
// - flush writes cache with retries under busy
// - flush failure loads address, drops sector
// - unsupported flush posts aborted error
// - buffer write: busy, request, interrupt, 512 bytes
`include "atbc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module atbc_cmd (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic intrq_o,
  output logic bsy_o,
  output logic drq_o,
  output atbc_pkg::atbc_mreq_t media_o,
  input wire atbc_pkg::atbc_mrsp_t media_i,
  input wire logic cache_dirty_i,
  output logic dma_go_o,
  output logic dma_wr_o,
  input wire logic dma_done_i
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rsync_q;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsync_q <= 2'h0;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n = rsync_q[1];

  // ----------------------------------------
  // state and sector buffer
  // ----------------------------------------
  atbc_pkg::atbc_state_t s_q, s_d;
  logic [15:0] buf_mem [256];
  logic step;
  logic dwr;
  logic launch;
  logic [7:0] cur;
  logic [7:0] stat;

  assign stat = {s_q.bsy, ~s_q.bsy, 2'h0, s_q.drq, 2'h0, s_q.err};

  always_ff @(posedge clk_i) begin
    if (dwr) begin
      buf_mem[s_q.widx] <= s_q.wd[15:0];
    end
  end

  always_comb begin
    s_d = s_q;
    step = 1'b0;
    dwr = 1'b0;
    launch = 1'b0;
    cur = 8'h0;
    s_d.mreq.req = s_q.mreq.req & ~media_i.ack;
    s_d.dma = 1'b0;
    // ----------------------------------------
    // bus read side
    // ----------------------------------------
    if (s_q.rv && s_axi_rready_i) begin
      s_d.rv = 1'b0;
      s_d.arrdy = 1'b1;
    end
    if (s_q.arrdy && s_axi_arvalid_i) begin
      s_d.arrdy = 1'b0;
      s_d.rv = 1'b1;
      s_d.rr = 2'h0;
      s_d.rd = 32'h0;
      unique case (s_axi_araddr_i)
        `ATBC_A_DATA: begin
          if (s_q.drq && !s_q.wr) begin
            s_d.rd = {16'h0, buf_mem[s_q.widx]};
            step = 1'b1;
          end
        end
        `ATBC_A_ERR: s_d.rd = 32'(({7'h0, s_q.unc} << `ATBC_E_UNC)
                                  | ({7'h0, s_q.abrt} << `ATBC_E_ABRT));
        `ATBC_A_SC: s_d.rd = {24'h0, s_q.sc};
        `ATBC_A_LBA: s_d.rd = {4'h0, s_q.lba};
        `ATBC_A_FEAT: s_d.rd = {24'h0, s_q.feat};
        `ATBC_A_STAT: begin
          s_d.rd = {14'h0, s_q.en, s_q.blk, s_q.intrq, stat};
          s_d.intrq = 1'b0;
        end
        `ATBC_A_CMD: s_d.rd = {24'h0, s_q.cmd};
        default: s_d.rr = 2'h3;
      endcase
    end
    // ----------------------------------------
    // bus write side
    // ----------------------------------------
    if (s_q.awrdy && s_axi_awvalid_i) begin
      s_d.awrdy = 1'b0;
      s_d.awok = 1'b1;
      s_d.awa = s_axi_awaddr_i;
    end
    if (s_q.wrdy && s_axi_wvalid_i) begin
      s_d.wrdy = 1'b0;
      s_d.wok = 1'b1;
      s_d.wd = s_axi_wdata_i;
      s_d.ws = s_axi_wstrb_i;
    end
    if (s_q.bv && s_axi_bready_i) begin
      s_d.bv = 1'b0;
      s_d.awrdy = 1'b1;
      s_d.wrdy = 1'b1;
    end
    if (s_q.awok && s_q.wok && !s_q.bv) begin
      s_d.awok = 1'b0;
      s_d.wok = 1'b0;
      s_d.bv = 1'b1;
      s_d.br = 2'h0;
      if (s_q.ws[0]) begin
        unique case (s_q.awa)
          `ATBC_A_DATA: begin
            if (s_q.drq && s_q.wr) begin
              dwr = 1'b1;
              step = 1'b1;
            end
          end
          `ATBC_A_SC: if (!s_q.bsy) s_d.sc = s_q.wd[7:0];
          `ATBC_A_LBA: if (!s_q.bsy) s_d.lba = s_q.wd[27:0];
          `ATBC_A_FEAT: if (!s_q.bsy) s_d.feat = s_q.wd[7:0];
          `ATBC_A_CMD: begin
            if (!s_q.bsy && !s_q.drq) begin
              launch = 1'b1;
              s_d.cmd = s_q.wd[7:0];
              s_d.st = atbc_pkg::ST_CMD;
              s_d.bsy = 1'b1;
              s_d.abrt = 1'b0;
              s_d.unc = 1'b0;
              s_d.err = 1'b0;
              s_d.intrq = 1'b0;
            end
          end
          `ATBC_A_ERR, `ATBC_A_STAT: ;
          default: s_d.br = 2'h3;
        endcase
      end
    end
    // ----------------------------------------
    // command sequencer
    // ----------------------------------------
    unique case (s_q.st)
      atbc_pkg::ST_IDLE: ;
      atbc_pkg::ST_CMD: begin
        s_d.st = atbc_pkg::ST_DONE;
        s_d.widx = 8'h0;
        s_d.retry = 3'h0;
        s_d.wr = (s_q.cmd == `ATBC_OP_WRMUL) || (s_q.cmd == `ATBC_OP_WRBUF);
        s_d.bufc = 1'b0;
        unique case (s_q.cmd)
          `ATBC_OP_RDMUL, `ATBC_OP_WRMUL: begin
            if (!s_q.en) begin
              s_d.abrt = 1'b1;
            end else begin
              s_d.rem = (s_q.sc == 8'h0) ? 9'h100 : {1'b0, s_q.sc};
              s_d.st = atbc_pkg::ST_BLK;
            end
          end
          `ATBC_OP_SETMUL: begin
            if (s_q.sc == 8'h0) begin
              s_d.en = 1'b0;
            end else if (s_q.sc > `ATBC_MAX_BLK) begin
              s_d.en = 1'b0;
              s_d.abrt = 1'b1;
            end else begin
              s_d.en = 1'b1;
              s_d.blk = s_q.sc;
            end
          end
          `ATBC_OP_RDBUF, `ATBC_OP_WRBUF: begin
            s_d.bufc = 1'b1;
            s_d.hsec = 8'h1;
            s_d.drq = 1'b1;
            s_d.bsy = 1'b0;
            s_d.intrq = 1'b1;
            s_d.st = atbc_pkg::ST_HOST;
          end
          // dma read on its own opcode
          // dma write on its own opcode
          `ATBC_OP_RDDMA, `ATBC_OP_WRDMA: begin
            s_d.dma = 1'b1;
            s_d.dmawr = (s_q.cmd == `ATBC_OP_WRDMA);
            s_d.st = atbc_pkg::ST_DMA;
          end
          `ATBC_OP_FLUSH: begin
            if (`ATBC_FLUSH_OK) begin
              s_d.st = atbc_pkg::ST_FLUSH;
            end else begin
              s_d.abrt = 1'b1;
            end
          end
          default: s_d.abrt = 1'b1;
        endcase
      end
      atbc_pkg::ST_BLK: begin
        cur = ({1'b0, s_q.blk} < s_q.rem) ? s_q.blk : s_q.rem[7:0];
        s_d.hsec = cur;
        s_d.sl = cur;
        s_d.widx = 8'h0;
        if (s_q.wr) begin
          s_d.drq = 1'b1;
          s_d.bsy = 1'b0;
          s_d.intrq = 1'b1;
          s_d.st = atbc_pkg::ST_HOST;
        end else begin
          s_d.err = 1'b0;
          s_d.mreq = '{1'b1, atbc_pkg::MOP_RD, s_q.lba};
          s_d.st = atbc_pkg::ST_MRD;
        end
      end
      atbc_pkg::ST_MRD: begin
        if (media_i.ack) begin
          s_d.lba = s_q.lba + 28'h1;
          s_d.rem = s_q.rem - 9'h1;
          s_d.sl = s_q.sl - 8'h1;
          if (media_i.err) begin
            s_d.unc = 1'b1;
            s_d.err = 1'b1;
          end
          if (s_q.sl == 8'h1) begin
            s_d.drq = 1'b1;
            s_d.bsy = 1'b0;
            s_d.intrq = 1'b1;
            s_d.st = atbc_pkg::ST_HOST;
          end else begin
            s_d.mreq = '{1'b1, atbc_pkg::MOP_RD, s_d.lba};
          end
        end
      end
      atbc_pkg::ST_HOST: begin
        if (step) begin
          s_d.widx = s_q.widx + 8'h1;
          if (s_q.widx == `ATBC_WORDS) begin
            s_d.hsec = s_q.hsec - 8'h1;
            if (s_q.hsec == 8'h1) begin
              s_d.drq = 1'b0;
              if (s_q.bufc) begin
                s_d.st = atbc_pkg::ST_IDLE;
              end else if (s_q.wr) begin
                s_d.bsy = 1'b1;
                s_d.mreq = '{1'b1, atbc_pkg::MOP_WR, s_q.lba};
                s_d.st = atbc_pkg::ST_MWR;
              end else if (s_q.rem == 9'h0) begin
                s_d.st = atbc_pkg::ST_IDLE;
              end else begin
                s_d.bsy = 1'b1;
                s_d.st = atbc_pkg::ST_BLK;
              end
            end
          end
        end
      end
      atbc_pkg::ST_MWR: begin
        if (media_i.ack) begin
          if (media_i.err) begin
            s_d.unc = 1'b1;
            s_d.err = 1'b1;
            s_d.st = atbc_pkg::ST_DONE;
          end else begin
            s_d.lba = s_q.lba + 28'h1;
            s_d.rem = s_q.rem - 9'h1;
            s_d.sl = s_q.sl - 8'h1;
            if (s_q.rem == 9'h1) begin
              s_d.st = atbc_pkg::ST_DONE;
            end else if (s_q.sl == 8'h1) begin
              s_d.st = atbc_pkg::ST_BLK;
            end else begin
              s_d.mreq = '{1'b1, atbc_pkg::MOP_WR, s_d.lba};
            end
          end
        end
      end
      atbc_pkg::ST_FLUSH: begin
        if (!s_q.mreq.req && !media_i.ack) begin
          if (cache_dirty_i) begin
            s_d.mreq = '{1'b1, atbc_pkg::MOP_FLUSH, s_q.lba};
          end else begin
            s_d.st = atbc_pkg::ST_DONE;
          end
        end else if (media_i.ack && media_i.err) begin
          s_d.retry = s_q.retry + 3'h1;
          if (s_q.retry == `ATBC_RETRY) begin
            s_d.lba = media_i.lba;
            s_d.unc = 1'b1;
            s_d.err = 1'b1;
            s_d.mreq = '{1'b1, atbc_pkg::MOP_DROP, media_i.lba};
            s_d.st = atbc_pkg::ST_DROP;
          end
        end else if (media_i.ack) begin
          s_d.retry = 3'h0;
        end
      end
      atbc_pkg::ST_DROP: if (media_i.ack) s_d.st = atbc_pkg::ST_DONE;
      atbc_pkg::ST_DMA: if (dma_done_i) s_d.st = atbc_pkg::ST_DONE;
      atbc_pkg::ST_DONE: begin
        s_d.bsy = 1'b0;
        s_d.err = s_q.err | s_q.abrt;
        s_d.intrq = 1'b1;
        s_d.st = atbc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= atbc_pkg::ST_IDLE;
      s_q.awrdy <= 1'b1;
      s_q.wrdy <= 1'b1;
      s_q.arrdy <= 1'b1;
      s_q.en <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready_o = s_q.awrdy;
  assign s_axi_wready_o = s_q.wrdy;
  assign s_axi_bresp_o = s_q.br;
  assign s_axi_bvalid_o = s_q.bv;
  assign s_axi_arready_o = s_q.arrdy;
  assign s_axi_rdata_o = s_q.rd;
  assign s_axi_rresp_o = s_q.rr;
  assign s_axi_rvalid_o = s_q.rv;
  assign intrq_o = s_q.intrq;
  assign bsy_o = s_q.bsy;
  assign drq_o = s_q.drq;
  assign media_o = s_q.mreq;
  assign dma_go_o = s_q.dma;
  assign dma_wr_o = s_q.dmawr;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  localparam int BSY_MAX = `ATBC_BSY_CYC;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_busy_fast: assert property (
    launch && s_q.wd[7:0] == `ATBC_OP_WRMUL |-> ##[1:BSY_MAX] s_q.bsy)
    else $error("busy late after block write");
  a_mult_abort: assert property (
    s_q.st == atbc_pkg::ST_CMD && !s_q.en && s_q.cmd inside {`ATBC_OP_RDMUL,
    `ATBC_OP_WRMUL} |=> s_q.abrt ##1 s_q.intrq && !s_q.bsy)
    else $error("disabled block command not aborted");
  a_read_blk: assert property (
    s_q.st == atbc_pkg::ST_MRD && media_i.ack && s_q.sl == 8'h1
    |=> s_q.drq && s_q.intrq && !s_q.bsy)
    else $error("no request after read block");
  a_write_blk: assert property (
    s_q.st == atbc_pkg::ST_BLK && s_q.wr |=> s_q.drq && s_q.intrq)
    else $error("no write request at block start");
  a_zero_off: assert property (
    s_q.st == atbc_pkg::ST_CMD && s_q.cmd == `ATBC_OP_SETMUL
    && s_q.sc == 8'h0 |=> !s_q.en && !s_q.abrt ##1 !s_q.bsy)
    else $error("zero count mishandled");
  a_bad_count: assert property (
    s_q.st == atbc_pkg::ST_CMD && s_q.cmd == `ATBC_OP_SETMUL
    && s_q.sc > `ATBC_MAX_BLK |=> !s_q.en && s_q.abrt)
    else $error("unsupported count accepted");
  a_good_count: assert property (
    s_q.st == atbc_pkg::ST_CMD && s_q.cmd == `ATBC_OP_SETMUL && s_q.sc != 8'h0
    && s_q.sc <= `ATBC_MAX_BLK |=> s_q.en && s_q.blk == $past(s_q.sc))
    else $error("valid count not stored");
  a_wr_stop: assert property (
    s_q.st == atbc_pkg::ST_MWR && media_i.ack && media_i.err
    |=> s_q.unc && s_q.lba == $past(s_q.lba) ##1 !s_q.bsy)
    else $error("write error did not end command");
  a_flush_fail: assert property (
    s_q.st == atbc_pkg::ST_FLUSH && media_i.ack && media_i.err
    && s_q.retry == `ATBC_RETRY |=> s_q.lba == $past(media_i.lba)
    && s_q.mreq.op == atbc_pkg::MOP_DROP)
    else $error("flush failure address wrong");
  a_count_hold: assert property (
    !(s_q.st == atbc_pkg::ST_CMD && s_q.cmd == `ATBC_OP_SETMUL)
    |=> $stable(s_q.en) && $stable(s_q.blk))
    else $error("block count changed unexpectedly");

  c_read_blk: cover property (s_q.st == atbc_pkg::ST_MRD ##1 s_q.drq);
  c_write_err: cover property (s_q.st == atbc_pkg::ST_MWR && media_i.ack && media_i.err);
  c_flush_drop: cover property (s_q.st == atbc_pkg::ST_DROP);
  c_buf_done: cover property (s_q.bufc && $fell(s_q.drq));

endmodule : atbc_cmd

`default_nettype wire

// ==== atbc_consts.svh ====
/*
  atbc_consts.svh: offsets, field positions, opcodes and timing counts
  of the block transfer command handler.
  assumes: included by bare name after the package.
*/
`ifndef ATBC_CONSTS_SVH
`define ATBC_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ATBC_A_DATA 8'h00
`define ATBC_A_ERR 8'h04
`define ATBC_A_SC 8'h08
`define ATBC_A_LBA 8'h0c
`define ATBC_A_FEAT 8'h10
`define ATBC_A_CMD 8'h14
`define ATBC_A_STAT 8'h18

// ----------------------------------------
// fields
// ----------------------------------------
`define ATBC_F_LONG 0
`define ATBC_E_ABRT 2
`define ATBC_E_UNC 6

// ----------------------------------------
// opcodes
// ----------------------------------------
`define ATBC_OP_RDMUL 8'hc4
`define ATBC_OP_WRMUL 8'hc5
`define ATBC_OP_SETMUL 8'hc6
`define ATBC_OP_RDDMA 8'hc8
`define ATBC_OP_WRDMA 8'hca
`define ATBC_OP_RDBUF 8'he4
`define ATBC_OP_FLUSH 8'he7
`define ATBC_OP_WRBUF 8'he8

// ----------------------------------------
// limits and timing
// ----------------------------------------
`define ATBC_MAX_BLK 8'h10
`define ATBC_FLUSH_OK 1'b1
`define ATBC_RETRY 3'h3
`define ATBC_WORDS 8'hff
`define ATBC_CLK_NS 8
`define ATBC_BSY_NS 400
`define ATBC_BSY_CYC (`ATBC_BSY_NS / `ATBC_CLK_NS)

`endif

// ==== atbc_pkg.sv ====
/*
  atbc_pkg.sv: types of the block transfer command handler.
  assumes: nothing beyond a SystemVerilog compiler.
*/
package atbc_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_BLK, ST_MRD, ST_HOST, ST_MWR,
    ST_FLUSH, ST_DROP, ST_DMA, ST_DONE
  } atbc_st_t;

  typedef enum logic [1:0] {MOP_RD, MOP_WR, MOP_FLUSH, MOP_DROP} atbc_mop_t;

  typedef struct packed {
    logic req;
    atbc_mop_t op;
    logic [27:0] lba;
  } atbc_mreq_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [27:0] lba;
  } atbc_mrsp_t;

  typedef struct packed {
    atbc_st_t st;
    logic awrdy;
    logic wrdy;
    logic awok;
    logic wok;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic arrdy;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [7:0] cmd;
    logic [7:0] sc;
    logic [27:0] lba;
    logic [7:0] feat;
    logic abrt;
    logic unc;
    logic err;
    logic bsy;
    logic drq;
    logic intrq;
    logic en;
    logic [7:0] blk;
    logic [8:0] rem;
    logic [7:0] hsec;
    logic [7:0] sl;
    logic [7:0] widx;
    logic wr;
    logic bufc;
    logic [2:0] retry;
    atbc_mreq_t mreq;
    logic dma;
    logic dmawr;
  } atbc_state_t;

endpackage : atbc_pkg

// ==== atbc_media_model.sv ====
/*
  atbc_media_model.sv: media and dma side partner of atbc_cmd.
  assumes: bench clock and reset; load_i sets the fail window and, when dirty_i is nonzero, the dirty count.
*/
`timescale 1ns/1ps
`default_nettype none

module atbc_media_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire atbc_pkg::atbc_mreq_t req_i,
  output atbc_pkg::atbc_mrsp_t rsp_o,
  input wire logic slow_i,
  input wire logic load_i,
  input wire logic [7:0] fail_i,
  input wire logic [3:0] dirty_i,
  output logic dirty_o,
  input wire logic dma_go_i,
  output logic dma_done_o
);
  logic ack_q;
  logic err_q;
  logic bad;
  logic [27:0] lba_q;
  int wait_q;
  int seen_q;
  int skip_q;
  int cnt_q;
  int dirty_q;
  int dma_q;

  // released lines show the inverse of the last value
  assign rsp_o = ack_q ? {1'h1, err_q, lba_q} : {1'h0, ~err_q, ~lba_q};
  assign dirty_o = dirty_q != 0;
  assign bad = seen_q >= skip_q && seen_q < skip_q + cnt_q
    && req_i.op != atbc_pkg::MOP_DROP;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'h0;
      err_q <= 1'h0;
      lba_q <= 28'h0;
      wait_q <= 0;
      seen_q <= 0;
      skip_q <= 0;
      cnt_q <= 0;
      dirty_q <= 0;
      dma_q <= 0;
      dma_done_o <= 1'h0;
    end else begin
      ack_q <= 1'h0;
      dma_done_o <= dma_q == 1;
      if (dma_go_i) begin
        dma_q <= 6;
      end else if (dma_q > 0) begin
        dma_q <= dma_q - 1;
      end
      if (load_i) begin
        skip_q <= fail_i[7:4];
        cnt_q <= fail_i[3:0];
        seen_q <= 0;
        if (dirty_i != 4'h0) begin
          dirty_q <= dirty_i;
        end
      end else if (req_i.req && !ack_q) begin
        wait_q <= wait_q + 1;
        if (wait_q >= (slow_i ? 7 : 1)) begin
          wait_q <= 0;
          seen_q <= seen_q + 1;
          ack_q <= 1'h1;
          err_q <= bad;
          lba_q <= req_i.op == atbc_pkg::MOP_FLUSH ? 28'h1000 + dirty_q : req_i.lba;
          // a successful flush and every drop retire a dirty sector
          if (req_i.op[1] && !bad) begin
            dirty_q <= dirty_q - 1;
          end
        end
      end
    end
  end
endmodule : atbc_media_model

`default_nettype wire

// ==== test_ata_block_transfer_cmds.sv ====
/*
  test_ata_block_transfer_cmds.sv: self-checking bench of atbc_cmd.
  assumes: package, constants header and media model compiled first.
*/
`include "atbc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module test_ata_block_transfer_cmds;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic arvalid = 1'h0;
  logic bready = 1'h1;
  logic rready = 1'h1;
  logic slow = 1'h0;
  logic load = 1'h0;
  logic [7:0] fail = 8'h0;
  logic [3:0] dn = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, intrq, bsy, drq;
  logic dirty, go, dwr, done, b_bsy, ib;
  logic [1:0] bresp, rresp, rr, br;
  logic [31:0] rdata;
  logic [31:0] seed = 32'hda5a93bd;
  atbc_pkg::atbc_mreq_t mreq;
  atbc_pkg::atbc_mrsp_t mrsp;
  logic m_en = 1'h0;
  int m_blk = 0;
  int scs[5] = '{4, 0, 17, 16, 4};
  logic [7:0] ops[2] = '{`ATBC_OP_RDDMA, `ATBC_OP_WRDMA};
  logic [15:0] buf_q[$];
  int nack = 0;
  int ngo = 0;
  int err_count = 0;
  int samples_checked = 0;

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (mrsp.ack === 1'h1) nack++;
    if (go === 1'h1) ngo++;
  end

  atbc_cmd u_atbc_cmd (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready),
    .intrq_o(intrq),
    .bsy_o(bsy),
    .drq_o(drq),
    .media_o(mreq),
    .media_i(mrsp),
    .cache_dirty_i(dirty),
    .dma_go_o(go),
    .dma_wr_o(dwr),
    .dma_done_i(done)
  );

  atbc_media_model u_atbc_media_model (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .req_i(mreq),
    .rsp_o(mrsp),
    .slow_i(slow),
    .load_i(load),
    .fail_i(fail),
    .dirty_i(dn),
    .dirty_o(dirty),
    .dma_go_i(go),
    .dma_done_o(done)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] stx(input logic b, d, e, i);
    return {14'h0, m_en, m_blk[7:0], i, b, !b, 2'h0, d, 2'h0, e};
  endfunction : stx

  task automatic complete_run();
    $display("errors=%0d checks=%0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tmo();
    err_count++;
    complete_run();
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (n = 0; n < 99; n++) begin
      @(negedge clk_i);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      b_bsy = bsy;
      br = bresp;
      @(posedge clk_i);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
      if (hb) break;
    end
    if (n == 99) tmo();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ha, hr;
    int n;
    araddr <= a;
    arvalid <= 1'h1;
    for (n = 0; n < 99; n++) begin
      @(negedge clk_i);
      ha = arvalid && arready;
      hr = rvalid;
      d = rdata;
      rr = rresp;
      @(posedge clk_i);
      if (ha) arvalid <= 1'h0;
      if (hr) break;
    end
    if (n == 99) tmo();
  endtask : rd

  task automatic wait_io(input logic want);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(negedge clk_i);
      ib = intrq;
      if (want ? drq === 1'h1 : (bsy === 1'h0 && drq === 1'h0)) break;
    end
    @(posedge clk_i);
    if (n == 3000) tmo();
  endtask : wait_io

  task automatic cmd(input logic [7:0] op, input logic [7:0] sc);
    wr(`ATBC_A_SC, {24'h0, sc});
    wr(`ATBC_A_CMD, {24'h0, op});
  endtask : cmd

  task automatic mload(input logic [7:0] f, input logic [3:0] d);
    fail <= f;
    dn <= d;
    load <= 1'h1;
    @(posedge clk_i);
    load <= 1'h0;
  endtask : mload

  task automatic drq_chk(input logic e);
    logic [31:0] s;
    wait_io(1'h1);
    chk(ib, 1'h1);
    rd(`ATBC_A_STAT, s);
    chk(s, stx(1'h0, 1'h1, e, 1'h1));
  endtask : drq_chk

  task automatic done_chk(input logic [31:0] ev, input logic iv);
    logic [31:0] s;
    wait_io(1'h0);
    chk(ib, iv);
    rd(`ATBC_A_ERR, s);
    chk(s, ev);
    rd(`ATBC_A_STAT, s);
    chk(s, stx(1'h0, 1'h0, ev != 0, iv));
  endtask : done_chk

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] s;
    logic [31:0] lb;
    int b;
    int tot;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    rd(`ATBC_A_STAT, s);
    chk(s, stx(1'h0, 1'h0, 1'h0, 1'h0));
    cmd(`ATBC_OP_RDMUL, 8'h04);
    done_chk(32'h4, 1'h1);
    rd(8'h1c, s);
    chk(rr, 2'h3);
    wr(8'h1c, 32'h0);
    chk(br, 2'h3);
    foreach (scs[i]) begin
      cmd(`ATBC_OP_SETMUL, scs[i][7:0]);
      m_en = scs[i] inside {[1:16]};
      if (m_en) m_blk = scs[i];
      done_chk(scs[i] > 16 ? 32'h4 : 32'h0, 1'h1);
      if (!m_en) begin
        cmd(`ATBC_OP_WRMUL, 8'h01);
        done_chk(32'h4, 1'h1);
      end
    end
    cmd(`ATBC_OP_WRBUF, 8'h01);
    drq_chk(1'h0);
    for (int k = 0; k < 256; k++) begin
      s = rnd();
      buf_q.push_back(s[15:0]);
      wr(`ATBC_A_DATA, {16'h0, s[15:0]});
    end
    done_chk(32'h0, 1'h0);
    cmd(`ATBC_OP_RDBUF, 8'h01);
    drq_chk(1'h0);
    foreach (buf_q[k]) begin
      rd(`ATBC_A_DATA, s);
      chk(s, {16'h0, buf_q[k]});
    end
    done_chk(32'h0, 1'h0);
    wr(`ATBC_A_FEAT, 32'h1);
    chk(br, 2'h0);
    mload(8'h01, 4'h0);
    nack = 0;
    cmd(`ATBC_OP_RDMUL, 8'h06);
    for (tot = 6; tot > 0; tot -= b) begin
      b = tot < m_blk ? tot : m_blk;
      drq_chk(tot == 6);
      chk(nack, 6 - tot + b);
      for (int k = 0; k < b * 256; k++) rd(`ATBC_A_DATA, s);
    end
    wait_io(1'h0);
    rd(`ATBC_A_STAT, s);
    chk(s & 32'h188, 32'h0);
    s = rnd();
    lb = {4'h0, s[27:0]};
    wr(`ATBC_A_LBA, lb);
    mload(8'h11, 4'h0);
    nack = 0;
    cmd(`ATBC_OP_WRMUL, 8'h06);
    chk(b_bsy, 1'h1);
    drq_chk(1'h0);
    for (int k = 0; k < 1024; k++) wr(`ATBC_A_DATA, rnd());
    done_chk(32'h40, 1'h1);
    chk(nack, 2);
    rd(`ATBC_A_LBA, s);
    chk(s, (lb + 32'h1) & 32'h0fffffff);
    mload(8'h04, 4'h3);
    nack = 0;
    cmd(`ATBC_OP_FLUSH, 8'h00);
    done_chk(32'h40, 1'h1);
    chk(nack, 5);
    rd(`ATBC_A_LBA, s);
    chk(s, 32'h1003);
    slow <= 1'h1;
    mload(8'h00, 4'h0);
    cmd(`ATBC_OP_FLUSH, 8'h00);
    done_chk(32'h0, 1'h1);
    chk(nack, 7);
    chk(dirty, 1'h0);
    foreach (ops[i]) begin
      cmd(ops[i], 8'h01);
      done_chk(32'h0, 1'h1);
      chk(dwr, ops[i] == `ATBC_OP_WRDMA);
    end
    chk(ngo, 2);
    complete_run();
  end
endmodule : test_ata_block_transfer_cmds

`default_nettype wire
